// ===== common/slmled_pkg.sv
// constants, register layout and mode type of the sleep-mode and indicator-pin block
//
// Behaviour
// - three low-power modes, hardware standby, hardware suspend, software suspend, via self_control.
// - leaving any low-power mode causes internal reset, then self-configuration.
// - self-configuration end sets init_done_flag and clears serial_if_busy_flag together.
// - in standby only link receiver lives; link activity drives activity_indicator low.
// - all register accesses ignored during hardware standby.
// - standby entered when pin low, pin_powerdown_enable set, standby_select_enable set.
// - standby entry resets everything except self_control.
// - standby exit performs complete reset and initialisation.
// - hardware suspend ignores register accesses and network activity.
// - suspend when pin low, enable set, standby select clear; pin high wakes.
// - software suspend keeps only io_base_address and self_control; the code also keeps init_done_flag and serial_if_busy_flag.
// - setting soft_powerdown_request enters software suspend.
// - any write wakes software suspend; data discarded, complete reset follows.
// - hardware reset leaves every low-power mode.
// - hardware modes beat software suspend; otherwise device stays fully operational.
// - activity_indicator low on tx, rx or collision, held 6 ms past last event.
// - link_indicator follows link pulses, or host_pin_zero_level when host_pin_zero_select set.
// - rx_transfer_indicator low on receive event read, or host_pin_one_level when selected.
// - init_done_flag sits at self_status bit 7.
// - serial_if_busy_flag sits at self_status bit 8.

package slmled_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS   = 40;
   localparam int unsigned NS_PER_MS       = 1000000;
   localparam int unsigned ACT_STRETCH_MS  = 6;
   localparam int unsigned CAL_TIME_MS     = 10;
   localparam int unsigned ACT_STRETCH_CYC =
      (ACT_STRETCH_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CAL_CYC         =
      (CAL_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 18;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [15:0] OFS_IO_BASE      = 16'h0020;
   localparam logic [15:0] OFS_SELF_CONTROL = 16'h0114;
   localparam logic [15:0] OFS_SELF_STATUS  = 16'h0116;
   localparam logic [15:0] OFS_RX_EVENT     = 16'h0124;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned BIT_SOFT_PD   = 8;
   localparam int unsigned BIT_PIN_PD_EN = 9;
   localparam int unsigned BIT_STBY_SEL  = 10;
   localparam int unsigned BIT_PIN0_SEL  = 12;
   localparam int unsigned BIT_PIN1_SEL  = 13;
   localparam int unsigned BIT_PIN0_LVL  = 14;
   localparam int unsigned BIT_PIN1_LVL  = 15;
   localparam int unsigned BIT_INIT_DONE = 7;
   localparam int unsigned BIT_SI_BUSY   = 8;

   // ---------------------------------------------------------------
   // reset values and masks
   // ---------------------------------------------------------------
   localparam logic [15:0] SELF_CONTROL_RST   = 16'h0000;
   localparam logic [15:0] SELF_CONTROL_WMASK = 16'hf700;
   localparam logic [15:0] IO_BASE_RST        = 16'h0000;

   typedef enum logic [2:0] {
      st_init,
      st_run,
      st_hw_standby,
      st_hw_suspend,
      st_sw_suspend
   } slmled_mode_t;

endpackage

// ===== sim/slmled_host_model.sv
// host-side model: register strobes and the power-down pin
`timescale 1ns/10ps

module slmled_host_model (
   input  wire logic        mclk_in,
   input  wire logic        init_done_in,
   input  wire logic [15:0] rdata_in,
   input  wire logic        rvalid_in,
   output logic             wr_out,
   output logic             rd_out,
   output logic [15:0]      addr_out,
   output logic [15:0]      wdata_out,
   output logic             sleep_n_out
);
   // ---------------------------------------------------------------
   // bus cycles
   // ---------------------------------------------------------------
   initial begin
      wr_out = 1'b0;
      rd_out = 1'b0;
      addr_out = 16'h0000;
      wdata_out = 16'h0000;
      sleep_n_out = 1'b1;
   end

   // released bus lines show the inverse, never the last value
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      #1;
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(posedge mclk_in);
      #1;
      wr_out = 1'b0;
      addr_out = ~a;
      wdata_out = ~d;
   endtask

   task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
      @(posedge mclk_in);
      #1;
      addr_out = a;
      rd_out = 1'b1;
      @(posedge mclk_in);
      #1;
      rd_out = 1'b0;
      addr_out = ~a;
      ok = rvalid_in;
      d = rdata_in;
   endtask

   task automatic pin(input logic v);
      sleep_n_out = v;
   endtask

   // no register access until calibration has ended
   task automatic wait_init(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 60 && !ok; i++) begin
         @(posedge mclk_in);
         #1;
         ok = (init_done_in === 1'b1);
      end
   endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench of the sleep-mode and indicator block
`timescale 1ns/10ps

module testbench;
   localparam int unsigned ACT = 5;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic tx = 1'b0, rx = 1'b0, col = 1'b0, lv = 1'b0, la = 1'b0;
   logic wr, rd, sn, rv, act_n, link_n, rxp_n, core_rst, idone, ok;
   logic [15:0] addr, wdata, rdata, d;
   int n_fail = 0;
   int n_compared = 0;

   always #20 mclk_in = ~mclk_in;

   slmled_host_model host_u (.mclk_in(mclk_in), .init_done_in(idone), .rdata_in(rdata),
      .rvalid_in(rv), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata),
      .sleep_n_out(sn));

   slmled_top #(.CAL_CYCLES(8), .ACT_CYCLES(ACT)) dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
      .sleep_n_in(sn), .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .tx_frame_in(tx), .rx_frame_in(rx), .collision_in(col),
      .link_valid_in(lv), .link_activity_in(la), .reg_rdata_out(rdata),
      .reg_rvalid_out(rv), .activity_indicator_n_out(act_n), .link_indicator_n_out(link_n),
      .rx_transfer_indicator_n_out(rxp_n), .core_reset_out(core_rst), .init_done_out(idone));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask

   task automatic stop_test;
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      #(40 * 4000);
      n_fail++;
      $display("wrong value at %0t: run hung", $time);
      stop_test;
   end

   initial begin
      cyc(20);
      rst_in = 1'b0;
      host_u.wait_init(ok);
      chk(16'(ok), 16'h0001, "init");
      host_u.rd(16'h0116, d, ok);
      chk({13'h0000, ok, d[8:7]}, 16'h0005, "status");
      host_u.wr(16'h0114, 16'hf6ff);
      host_u.rd(16'h0114, d, ok);
      chk(d, 16'hf600, "ctl");
      chk({14'h0000, link_n, rxp_n}, 16'h0000, "host low");
      host_u.wr(16'h0114, 16'h3000);
      cyc(2);
      chk({14'h0000, link_n, rxp_n}, 16'h0003, "host high");
      host_u.wr(16'h0114, 16'h0000);
      lv = 1'b1;
      cyc(2);
      chk(16'(link_n), 16'h0000, "link on");
      lv = 1'b0;
      cyc(2);
      chk(16'(link_n), 16'h0001, "link off");
      host_u.rd(16'h0124, d, ok);
      chk(16'(rxp_n), 16'h0000, "rx read");
      cyc(1);
      chk(16'(rxp_n), 16'h0001, "rx idle");
      host_u.wr(16'h0020, 16'h1234);
      host_u.rd(16'h0020, d, ok);
      chk(d, 16'h1234, "io base");
      host_u.rd(16'h0300, d, ok);
      chk({ok, d[14:0]}, 16'h8000, "unmapped");
      // events three cycles apart keep the pin low without a gap
      for (int i = 0; i < 3; i++) begin
         {tx, rx, col} = 3'(3'b100 >> i);
         cyc(1);
         {tx, rx, col} = 3'b000;
         cyc(2);
         chk(16'(act_n), 16'h0000, "activity");
      end
      // pin trails the stretcher by one edge: last low cycle, then high
      cyc(ACT - 2);
      chk(16'(act_n), 16'h0000, "retrigger");
      cyc(1);
      chk(16'(act_n), 16'h0001, "act end");
      host_u.wr(16'h0114, 16'h0100);
      cyc(2);
      chk(16'(core_rst), 16'h0001, "sw sleep");
      host_u.rd(16'h0114, d, ok);
      chk(16'(ok), 16'h0000, "sw read");
      host_u.wr(16'h0300, 16'hffff);
      cyc(1);
      chk(16'(idone), 16'h0000, "wake");
      host_u.wait_init(ok);
      host_u.rd(16'h0114, d, ok);
      chk(d, 16'h0000, "wake ctl");
      host_u.wr(16'h0114, 16'h0600);
      host_u.pin(1'b0);
      cyc(3);
      chk({core_rst, idone}, 16'h0002, "standby");
      la = 1'b1;
      cyc(2);
      chk(16'(act_n), 16'h0000, "stby link");
      host_u.rd(16'h0114, d, ok);
      chk(16'(ok), 16'h0000, "stby read");
      host_u.wr(16'h0020, 16'h5555);
      host_u.pin(1'b1);
      host_u.wait_init(ok);
      host_u.rd(16'h0020, d, ok);
      chk(d, 16'h0000, "stby exit");
      host_u.pin(1'b0);
      cyc(3);
      chk(16'(core_rst), 16'h0000, "pin only");
      host_u.wr(16'h0114, 16'h0300);
      cyc(3);
      chk({act_n, core_rst}, 16'h0003, "suspend");
      host_u.wr(16'h0300, 16'h0000);
      cyc(3);
      chk(16'(core_rst), 16'h0001, "hw first");
      rst_in = 1'b1;
      cyc(2);
      rst_in = 1'b0;
      la = 1'b0;
      host_u.wait_init(ok);
      chk(16'(ok), 16'h0001, "hw reset");
      stop_test;
   end
endmodule

// ===== verilog/slmled_stretch.sv
// retriggerable pulse stretcher for the activity indicator
`timescale 1ns/10ps

module slmled_stretch #(
   parameter int unsigned CYCLES = slmled_pkg::ACT_STRETCH_CYC
) (
   input  wire logic mclk_in,
   input  wire logic rst_in,
   input  wire logic clear_in,
   input  wire logic event_in,
   output logic      active_out
);

   typedef struct packed {
      logic [slmled_pkg::CNT_W-1:0] cnt;
      logic                         active;
   } slmled_stretch_t;

   localparam logic [slmled_pkg::CNT_W-1:0] LOAD = slmled_pkg::CNT_W'(CYCLES - 1);

   slmled_stretch_t st;
   slmled_stretch_t next_st;

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (clear_in) begin
         next_st.cnt    = '0;
         next_st.active = 1'b0;
      end else if (event_in) begin
         // every event reloads, so the pulse ends CYCLES after the last one
         next_st.cnt    = LOAD;
         next_st.active = 1'b1;
      end else if (st.cnt != '0) begin
         next_st.cnt = st.cnt - 1'b1;
      end else begin
         next_st.active = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign active_out = st.active;

endmodule

// ===== verilog/slmled_top.sv
// low-power mode sequencer with indicator-pin control
`timescale 1ns/10ps

module slmled_top #(
   parameter int unsigned CAL_CYCLES = slmled_pkg::CAL_CYC,
   parameter int unsigned ACT_CYCLES = slmled_pkg::ACT_STRETCH_CYC
) (
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        sleep_n_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [15:0] reg_addr_in,
   input  wire logic [15:0] reg_wdata_in,
   input  wire logic        tx_frame_in,
   input  wire logic        rx_frame_in,
   input  wire logic        collision_in,
   input  wire logic        link_valid_in,
   input  wire logic        link_activity_in,
   output logic [15:0]      reg_rdata_out,
   output logic             reg_rvalid_out,
   output logic             activity_indicator_n_out,
   output logic             link_indicator_n_out,
   output logic             rx_transfer_indicator_n_out,
   output logic             core_reset_out,
   output logic             init_done_out
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      slmled_pkg::slmled_mode_t     mode;
      logic [slmled_pkg::CNT_W-1:0] cal_cnt;
      logic [15:0]                  self_control;
      logic [15:0]                  io_base;
      logic                         init_done;
      logic                         si_busy;
      logic [15:0]                  rdata;
      logic                         rvalid;
      logic                         act_n;
      logic                         link_n;
      logic                         rxt_n;
      logic                         core_reset;
   } slmled_state_t;

   localparam logic [slmled_pkg::CNT_W-1:0] CAL_LOAD =
      slmled_pkg::CNT_W'(CAL_CYCLES - 1);

   slmled_state_t st;
   slmled_state_t next_st;

   logic act_active;
   logic act_event;
   logic act_clear;
   logic hw_sleep;
   logic bus_open;

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic pin_mux(input logic sel, input logic lvl, input logic own_low);
      // pins are active low: host level 1 pulls the pin low
      pin_mux = sel ? ~lvl : ~own_low;
   endfunction

   function automatic logic is_hw_mode(input slmled_pkg::slmled_mode_t m);
      is_hw_mode = (m == slmled_pkg::st_hw_standby) || (m == slmled_pkg::st_hw_suspend);
   endfunction

   assign hw_sleep  = ~sleep_n_in & st.self_control[slmled_pkg::BIT_PIN_PD_EN];
   assign bus_open  = (st.mode == slmled_pkg::st_run) || (st.mode == slmled_pkg::st_init);
   assign act_event = bus_open & (tx_frame_in | rx_frame_in | collision_in);
   // the stretcher is one of the circuits that every sleep mode resets
   assign act_clear = ~bus_open;

   slmled_stretch #(
      .CYCLES (ACT_CYCLES)
   ) u_stretch (
      .mclk_in    (mclk_in),
      .rst_in     (rst_in),
      .clear_in   (act_clear),
      .event_in   (act_event),
      .active_out (act_active)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st        = st;
      next_st.rvalid = 1'b0;
      next_st.rdata  = 16'h0000;
      next_st.rxt_n  = 1'b1;

      case (st.mode)
         slmled_pkg::st_init,
         slmled_pkg::st_run,
         slmled_pkg::st_sw_suspend: begin
            if (hw_sleep) begin
               // hardware modes win over software suspend and over any access
               if (st.self_control[slmled_pkg::BIT_STBY_SEL]) begin
                  next_st.mode = slmled_pkg::st_hw_standby;
               end else begin
                  next_st.mode = slmled_pkg::st_hw_suspend;
               end
               // everything but self_control goes back to reset
               next_st.io_base   = slmled_pkg::IO_BASE_RST;
               next_st.init_done = 1'b0;
               next_st.si_busy   = 1'b0;
               next_st.cal_cnt   = '0;
            end else if (st.mode == slmled_pkg::st_sw_suspend) begin
               if (reg_wr_in) begin
                  // the waking write is dropped, then a complete reset
                  next_st.mode         = slmled_pkg::st_init;
                  next_st.self_control = slmled_pkg::SELF_CONTROL_RST;
                  next_st.io_base      = slmled_pkg::IO_BASE_RST;
                  next_st.init_done    = 1'b0;
                  next_st.si_busy      = 1'b1;
                  next_st.cal_cnt      = CAL_LOAD;
               end
               // io_base, self_control and both status flags keep their values here
            end else begin
               if (st.mode == slmled_pkg::st_init) begin
                  if (st.cal_cnt == '0) begin
                     // both flags flip in the same edge
                     next_st.mode      = slmled_pkg::st_run;
                     next_st.init_done = 1'b1;
                     next_st.si_busy   = 1'b0;
                  end else begin
                     // software is expected to stay away meanwhile
                     next_st.cal_cnt = st.cal_cnt - 1'b1;
                  end
               end else if (st.self_control[slmled_pkg::BIT_SOFT_PD]) begin
                  next_st.mode = slmled_pkg::st_sw_suspend;
               end

               if (reg_wr_in) begin
                  case (reg_addr_in)
                     slmled_pkg::OFS_SELF_CONTROL: begin
                        next_st.self_control = reg_wdata_in & slmled_pkg::SELF_CONTROL_WMASK;
                     end
                     slmled_pkg::OFS_IO_BASE: begin
                        next_st.io_base = reg_wdata_in;
                     end
                     default: begin
                        next_st.io_base = st.io_base;
                     end
                  endcase
               end

               if (reg_rd_in) begin
                  next_st.rvalid = 1'b1;
                  case (reg_addr_in)
                     slmled_pkg::OFS_SELF_CONTROL: begin
                        next_st.rdata = st.self_control;
                     end
                     slmled_pkg::OFS_IO_BASE: begin
                        next_st.rdata = st.io_base;
                     end
                     slmled_pkg::OFS_SELF_STATUS: begin
                        next_st.rdata[slmled_pkg::BIT_INIT_DONE] = st.init_done;
                        next_st.rdata[slmled_pkg::BIT_SI_BUSY]   = st.si_busy;
                     end
                     slmled_pkg::OFS_RX_EVENT: begin
                        // contents come from the receive logic; only the read is seen here
                        next_st.rxt_n = 1'b0;
                     end
                     default: begin
                        next_st.rdata = 16'h0000;
                     end
                  endcase
               end
            end
         end

         slmled_pkg::st_hw_standby,
         slmled_pkg::st_hw_suspend: begin
            // bus accesses simply fall on the floor
            if (sleep_n_in) begin
               // pin back high: complete reset and initialisation
               next_st.mode         = slmled_pkg::st_init;
               next_st.self_control = slmled_pkg::SELF_CONTROL_RST;
               next_st.io_base      = slmled_pkg::IO_BASE_RST;
               next_st.init_done    = 1'b0;
               next_st.si_busy      = 1'b1;
               next_st.cal_cnt      = CAL_LOAD;
            end else if (!st.self_control[slmled_pkg::BIT_PIN_PD_EN]) begin
               next_st.mode = slmled_pkg::st_init;
            end else if (st.self_control[slmled_pkg::BIT_STBY_SEL]) begin
               next_st.mode = slmled_pkg::st_hw_standby;
            end else begin
               next_st.mode = slmled_pkg::st_hw_suspend;
            end
         end

         default: begin
            next_st.mode = slmled_pkg::st_init;
         end
      endcase

      // indicator pins, low active
      case (st.mode)
         slmled_pkg::st_init,
         slmled_pkg::st_run: begin
            next_st.act_n  = ~act_active;
            next_st.link_n = pin_mux(st.self_control[slmled_pkg::BIT_PIN0_SEL],
                                     st.self_control[slmled_pkg::BIT_PIN0_LVL],
                                     link_valid_in);
            if (st.self_control[slmled_pkg::BIT_PIN1_SEL]) begin
               next_st.rxt_n = ~st.self_control[slmled_pkg::BIT_PIN1_LVL];
            end
         end
         slmled_pkg::st_hw_standby: begin
            // the twisted-pair receiver is the only thing left listening
            next_st.act_n  = ~link_activity_in;
            next_st.link_n = pin_mux(st.self_control[slmled_pkg::BIT_PIN0_SEL],
                                     st.self_control[slmled_pkg::BIT_PIN0_LVL],
                                     link_valid_in);
         end
         default: begin
            // isolated core: network ignored, pins parked high
            next_st.act_n  = 1'b1;
            next_st.link_n = 1'b1;
         end
      endcase

      next_st.core_reset = (next_st.mode != slmled_pkg::st_run);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         // hardware reset ends any sleep mode and starts calibration
         st              <= '0;
         st.mode         <= slmled_pkg::st_init;
         st.cal_cnt      <= CAL_LOAD;
         st.self_control <= slmled_pkg::SELF_CONTROL_RST;
         st.io_base      <= slmled_pkg::IO_BASE_RST;
         st.si_busy      <= 1'b1;
         st.act_n        <= 1'b1;
         st.link_n       <= 1'b1;
         st.rxt_n        <= 1'b1;
         st.core_reset   <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata_out               = st.rdata;
   assign reg_rvalid_out              = st.rvalid;
   assign activity_indicator_n_out    = st.act_n;
   assign link_indicator_n_out        = st.link_n;
   assign rx_transfer_indicator_n_out = st.rxt_n;
   assign core_reset_out              = st.core_reset;
   assign init_done_out               = st.init_done;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   AST_INIT_FLAGS: assert property (
      (st.mode == slmled_pkg::st_init && st.cal_cnt == '0 && !hw_sleep)
      |=> st.mode == slmled_pkg::st_run && st.init_done && !st.si_busy && $past(st.si_busy))
      else $error("init done and busy flags did not switch together");

   AST_STANDBY_ENTRY: assert property (
      (!is_hw_mode(st.mode) && !sleep_n_in
       && st.self_control[slmled_pkg::BIT_PIN_PD_EN] && st.self_control[slmled_pkg::BIT_STBY_SEL])
      |=> st.mode == slmled_pkg::st_hw_standby && st.io_base == slmled_pkg::IO_BASE_RST
          && st.self_control == $past(st.self_control) && !st.init_done)
      else $error("standby entry wrong");

   AST_SUSPEND_ENTRY: assert property (
      (!is_hw_mode(st.mode) && !sleep_n_in
       && st.self_control[slmled_pkg::BIT_PIN_PD_EN] && !st.self_control[slmled_pkg::BIT_STBY_SEL])
      |=> st.mode == slmled_pkg::st_hw_suspend)
      else $error("suspend entry wrong");

   AST_HW_WAKE: assert property (
      (is_hw_mode(st.mode) && sleep_n_in)
      |=> st.mode == slmled_pkg::st_init && st.si_busy && !st.init_done
          && st.self_control == slmled_pkg::SELF_CONTROL_RST && st.core_reset)
      else $error("wake from hardware mode without complete reset");

   AST_SW_ENTER: assert property (
      (st.mode == slmled_pkg::st_run && st.self_control[slmled_pkg::BIT_SOFT_PD] && !hw_sleep)
      |=> st.mode == slmled_pkg::st_sw_suspend ##1 st.mode == slmled_pkg::st_sw_suspend
          || $past(reg_wr_in))
      else $error("soft suspend not entered");

   AST_SW_WAKE: assert property (
      (st.mode == slmled_pkg::st_sw_suspend && reg_wr_in && !hw_sleep)
      |=> st.mode == slmled_pkg::st_init && st.self_control == slmled_pkg::SELF_CONTROL_RST
          && st.io_base == slmled_pkg::IO_BASE_RST && !st.rvalid)
      else $error("soft suspend wake wrong");

   AST_BUS_IGNORED: assert property (
      (is_hw_mode(st.mode) && (reg_rd_in || reg_wr_in))
      |=> !st.rvalid && (st.self_control == $past(st.self_control) || $past(sleep_n_in)))
      else $error("bus access honoured in hardware mode");

   AST_PRIORITY: assert property (
      (st.mode == slmled_pkg::st_sw_suspend && hw_sleep) |=> is_hw_mode(st.mode))
      else $error("soft suspend beat hardware mode");

   AST_FULL_OP: assert property (
      (st.mode == slmled_pkg::st_run && !hw_sleep && !st.self_control[slmled_pkg::BIT_SOFT_PD])
      |=> st.mode == slmled_pkg::st_run && !st.core_reset)
      else $error("left operation without cause");

   AST_ACT_LOW: assert property (
      (st.mode == slmled_pkg::st_run && act_event && !hw_sleep
       && !st.self_control[slmled_pkg::BIT_SOFT_PD])
      |=> ##1 !st.act_n)
      else $error("activity pin not low after event");

   AST_STANDBY_LED: assert property (
      (st.mode == slmled_pkg::st_hw_standby && !sleep_n_in && link_activity_in
       && st.self_control[slmled_pkg::BIT_PIN_PD_EN] && st.self_control[slmled_pkg::BIT_STBY_SEL])
      |=> !st.act_n)
      else $error("standby link activity not shown");

   AST_LINK_PIN: assert property (
      (st.mode == slmled_pkg::st_run)
      |=> st.link_n == ($past(st.self_control[slmled_pkg::BIT_PIN0_SEL])
                        ? !$past(st.self_control[slmled_pkg::BIT_PIN0_LVL]) : !$past(link_valid_in)))
      else $error("link pin wrong");

   AST_RXT_PIN: assert property (
      (st.mode == slmled_pkg::st_run && !hw_sleep && reg_rd_in
       && reg_addr_in == slmled_pkg::OFS_RX_EVENT && !st.self_control[slmled_pkg::BIT_PIN1_SEL])
      |=> !st.rxt_n ##1 (st.rxt_n || $past(reg_rd_in)))
      else $error("receive transfer pin wrong");

   AST_ACT_HOLD: assert property (
      (st.mode == slmled_pkg::st_run && act_active)
      |=> !st.act_n)
      else $error("activity pin released while stretch running");

endmodule
